// ### logic/dds_pkg.sv
// Purpose: shared constants for the synthesizer serial link and its two ends
// Assumes: one clock, sys_clk at 100 MHz; serial clock made by the host end
// Notes: word layout and control bit positions are fixed here for both ends
// Function
// - frequency pin level picks frequency word
// - frequency choice from pin or bit
// - host holds frequency pin steady in bit mode
// - phase pin level picks phase offset
// - phase choice from pin or bit
// - host holds phase pin steady in bit mode
// - reset input zeroes accumulator, output midscale
// - reset input keeps all written registers
// - power-down pin high powers DAC down
// - power-down pin or bit, either works
// - each frame carries exactly sixteen bits
// - data sampled on serial clock falling edge
// - frame sync low starts a new word
// - logic output driven only when enabled
// - logic output from comparator or phase msb
// - both bits set: comparator uses external pin
// - all phase stepping on the master clock
// - 28-bit accumulator adds chosen word each cycle
// - 12-bit offset added to accumulator msbs
// - adjusted phase truncated to 12 bits
// - word switch keeps accumulator, phase continuous
package dds_pkg;
    localparam int WORD_BITS = 16;
    localparam int ACC_BITS = 28;
    localparam int HALF_BITS = 14;
    localparam int PHASE_BITS = 12;
    localparam int CNT_BITS = 5;
    // word type field in bits 15:14
    localparam int TYPE_HI = 15;
    localparam int TYPE_LO = 14;
    localparam logic [1:0] TYPE_CONTROL = 2'h0;
    localparam logic [1:0] TYPE_FREQ_A = 2'h1;
    localparam logic [1:0] TYPE_FREQ_B = 2'h2;
    localparam logic [1:0] TYPE_PHASE = 2'h3;
    // phase word: bit 13 picks offset b
    localparam int PHASE_DEST_POS = 13;
    // control word bit positions
    localparam int CTL_FREQ_HALF_POS = 0;
    localparam int CTL_FREQ_BIT_POS = 1;
    localparam int CTL_PHASE_BIT_POS = 2;
    localparam int CTL_PIN_MODE_POS = 3;
    localparam int CTL_POWERDOWN_POS = 4;
    localparam int CTL_OUT_ENABLE_POS = 5;
    localparam int CTL_OUT_SOURCE_POS = 6;
    localparam int CTL_BITS = 7;
    localparam logic [CTL_BITS-1:0] CTL_RESET = 7'h08;
    localparam logic [ACC_BITS-1:0] FREQ_RESET = 28'h0000000;
    localparam logic [PHASE_BITS-1:0] PHASE_RESET = 12'h000;
    // serial clock timing
    localparam int SYS_PERIOD_NS = 10;
    localparam int SCLK_PERIOD_NS = 40;
    localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
    localparam int HALF_CNT_BITS = 4;
endpackage

// ### logic/dds_link_if.sv
`timescale 1ns/1ps
// Purpose: pin-level link between host and synthesizer
// Assumes: all signals change only on sys_clk edges
// Notes: serial clock idles high between frames
interface dds_link_if;
    logic sclk;
    logic serial_data_in;
    logic frame_sync_n;
    logic freq_choice_pin;
    logic phase_choice_pin;
    logic accum_clear;
    logic powerdown_pin;

    modport device (
        input sclk,
        input serial_data_in,
        input frame_sync_n,
        input freq_choice_pin,
        input phase_choice_pin,
        input accum_clear,
        input powerdown_pin
    );
    modport host (
        output sclk,
        output serial_data_in,
        output frame_sync_n,
        output freq_choice_pin,
        output phase_choice_pin,
        output accum_clear,
        output powerdown_pin
    );
endinterface

// ### logic/dds_device.sv
`timescale 1ns/1ps
// Purpose: digital core of the synthesizer: serial load, word select, accumulator
// Assumes: link pins synchronous to sys_clk; sclk made by the host from sys_clk
// Notes: rst sets writable state; link accum_clear only clears working state
module dds_device
    import dds_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    dds_link_if.device link,
    input wire logic comparator_result,
    output logic [PHASE_BITS-1:0] phase_addr,
    output logic dac_powerdown,
    output logic logic_out,
    output logic logic_out_oe,
    output logic comparator_from_pin,
    output logic word_loaded
);
    // serial receive state
    logic sclk_prev;
    logic sync_prev;
    logic in_frame;
    logic [CNT_BITS-1:0] bit_count;
    logic [WORD_BITS-1:0] shift_word;
    logic commit;
    logic [WORD_BITS-1:0] next_word;

    // written registers, kept across accum_clear
    logic [CTL_BITS-1:0] control;
    logic [ACC_BITS-1:0] freq_word_a;
    logic [ACC_BITS-1:0] freq_word_b;
    logic [PHASE_BITS-1:0] phase_offset_a;
    logic [PHASE_BITS-1:0] phase_offset_b;

    // selection and phase datapath
    logic freq_pin_q;
    logic phase_pin_q;
    logic use_freq_b;
    logic use_phase_b;
    logic [ACC_BITS-1:0] accumulator;
    logic [ACC_BITS-1:0] step_word;
    logic [PHASE_BITS-1:0] offset_word;
    logic falling;

    // decoded control bits
    logic freq_choice_bit;
    logic phase_bit;
    logic pin_mode;
    logic dac_powerdown_bit;
    logic logic_out_enable;
    logic logic_out_source;

    // control bits decoded once for the muxes below
    assign freq_choice_bit = control[CTL_FREQ_BIT_POS];
    assign phase_bit = control[CTL_PHASE_BIT_POS];
    assign pin_mode = control[CTL_PIN_MODE_POS];
    assign dac_powerdown_bit = control[CTL_POWERDOWN_POS];
    assign logic_out_enable = control[CTL_OUT_ENABLE_POS];
    assign logic_out_source = control[CTL_OUT_SOURCE_POS];

    // edge history of the link pins; inputs are already on sys_clk
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sclk_prev <= 1'b1;
            sync_prev <= 1'b1;
        end else begin
            sclk_prev <= link.sclk;
            sync_prev <= link.frame_sync_n;
        end
    end

    // a fall is sclk seen high then low on two edges; two-cycle halves keep each fall visible
    assign falling = sclk_prev & ~link.sclk;
    assign next_word = {shift_word[WORD_BITS-2:0], link.serial_data_in};

    // frame tracking: a frame that ends early is dropped, never half-applied
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_frame <= 1'b0;
            bit_count <= '0;
            shift_word <= '0;
        end else if (link.frame_sync_n) begin
            // sync high ends any frame; a short one never reaches commit
            in_frame <= 1'b0;
            bit_count <= '0;
        end else if (sync_prev) begin
            in_frame <= 1'b1;
            bit_count <= '0;
            if (falling) begin
                shift_word <= next_word;
                bit_count <= CNT_BITS'(1);
            end
        end else if (in_frame && falling) begin
            shift_word <= next_word;
            if (bit_count == CNT_BITS'(WORD_BITS - 1)) begin
                in_frame <= 1'b0;
                bit_count <= '0;
            end else begin
                bit_count <= bit_count + CNT_BITS'(1);
            end
        end
    end

    // sixteenth falling edge of a live frame delivers the word
    assign commit = ~link.frame_sync_n & ~sync_prev & in_frame & falling
        & (bit_count == CNT_BITS'(WORD_BITS - 1));

    // writable registers: rst resets them and commit writes them, never accum_clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            control <= CTL_RESET;
            freq_word_a <= FREQ_RESET;
            freq_word_b <= FREQ_RESET;
            phase_offset_a <= PHASE_RESET;
            phase_offset_b <= PHASE_RESET;
        end else if (commit) begin
            // top two bits of the word choose the destination
            case (next_word[TYPE_HI:TYPE_LO])
                TYPE_CONTROL: begin
                    control <= next_word[CTL_BITS-1:0];
                end
                TYPE_FREQ_A: begin
                    if (control[CTL_FREQ_HALF_POS]) begin
                        freq_word_a[ACC_BITS-1:HALF_BITS] <= next_word[HALF_BITS-1:0];
                    end else begin
                        freq_word_a[HALF_BITS-1:0] <= next_word[HALF_BITS-1:0];
                    end
                end
                TYPE_FREQ_B: begin
                    if (control[CTL_FREQ_HALF_POS]) begin
                        freq_word_b[ACC_BITS-1:HALF_BITS] <= next_word[HALF_BITS-1:0];
                    end else begin
                        freq_word_b[HALF_BITS-1:0] <= next_word[HALF_BITS-1:0];
                    end
                end
                default: begin
                    if (next_word[PHASE_DEST_POS]) begin
                        phase_offset_b <= next_word[PHASE_BITS-1:0];
                    end else begin
                        phase_offset_a <= next_word[PHASE_BITS-1:0];
                    end
                end
            endcase
        end
    end

    // one-cycle flag that a full word was taken
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            word_loaded <= 1'b0;
        end else begin
            word_loaded <= commit;
        end
    end

    // select pins registered so the switch lands on a clock edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            freq_pin_q <= 1'b0;
            phase_pin_q <= 1'b0;
        end else begin
            freq_pin_q <= link.freq_choice_pin;
            phase_pin_q <= link.phase_choice_pin;
        end
    end

    // pin mode follows the sampled pins; bit mode ignores them
    assign use_freq_b = pin_mode ? freq_pin_q : freq_choice_bit;
    assign use_phase_b = pin_mode ? phase_pin_q : phase_bit;
    assign step_word = use_freq_b ? freq_word_b : freq_word_a;
    assign offset_word = use_phase_b ? phase_offset_b : phase_offset_a;

    // accumulator wraps modulo 2^28; a word switch only changes the step
    always_ff @(posedge sys_clk) begin
        if (rst || link.accum_clear) begin
            accumulator <= '0;
        end else begin
            accumulator <= accumulator + step_word;
        end
    end

    // phase offset on the top bits, carry out dropped to keep 12 bits
    always_ff @(posedge sys_clk) begin
        if (rst || link.accum_clear) begin
            phase_addr <= '0;
        end else begin
            phase_addr <= accumulator[ACC_BITS-1 -: PHASE_BITS] + offset_word;
        end
    end

    // power-down: pin and bit are an OR, registered to avoid glitches
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dac_powerdown <= 1'b0;
        end else begin
            dac_powerdown <= link.powerdown_pin | dac_powerdown_bit;
        end
    end

    // logic output: source mux, enable, and comparator input routing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            logic_out <= 1'b0;
            logic_out_oe <= 1'b0;
            comparator_from_pin <= 1'b0;
        end else begin
            logic_out <= logic_out_enable
                & (logic_out_source ? comparator_result : phase_addr[PHASE_BITS-1]);
            logic_out_oe <= logic_out_enable;
            comparator_from_pin <= logic_out_enable & logic_out_source;
        end
    end
endmodule

// ### logic/dds_host.sv
`timescale 1ns/1ps
// Purpose: host end that serialises 16-bit words and drives the select pins
// Assumes: one word at a time from the user side, valid/ready handshake
// Notes: sclk is divided from sys_clk; data changes only while sclk is high
module dds_host
    import dds_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    dds_link_if.host link,
    input wire logic cmd_valid,
    input wire logic [WORD_BITS-1:0] cmd_word,
    output logic cmd_ready,
    input wire logic freq_select,
    input wire logic phase_select,
    input wire logic clear_request,
    input wire logic powerdown_request
);
    typedef enum logic [3:0] {
        IDLE = 4'h1,
        START = 4'h2,
        HIGH = 4'h4,
        LOW = 4'h8
    } host_state_e;

    host_state_e state;
    logic [WORD_BITS-1:0] shift_word;
    logic [CNT_BITS-1:0] bits_left;
    logic [HALF_CNT_BITS-1:0] half_count;
    logic half_done;

    assign half_done = half_count == HALF_CNT_BITS'(SCLK_HALF_CYCLES - 1);
    assign cmd_ready = state == IDLE;

    // plain pins follow the user levels one clock later
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            link.freq_choice_pin <= 1'b0;
            link.phase_choice_pin <= 1'b0;
            link.accum_clear <= 1'b0;
            link.powerdown_pin <= 1'b0;
        end else begin
            link.freq_choice_pin <= freq_select;
            link.phase_choice_pin <= phase_select;
            link.accum_clear <= clear_request;
            link.powerdown_pin <= powerdown_request;
        end
    end

    // frame sequencer: sync low, then 16 high/low sclk half pairs, then release
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= IDLE;
            shift_word <= '0;
            bits_left <= '0;
            half_count <= '0;
            link.sclk <= 1'b1;
            link.frame_sync_n <= 1'b1;
            link.serial_data_in <= 1'b0;
        end else begin
            half_count <= half_done ? '0 : half_count + HALF_CNT_BITS'(1);
            case (state)
                IDLE: begin
                    half_count <= '0;
                    if (cmd_valid) begin
                        shift_word <= cmd_word;
                        bits_left <= CNT_BITS'(WORD_BITS);
                        link.frame_sync_n <= 1'b0;
                        state <= START;
                    end
                end
                START: begin
                    link.serial_data_in <= shift_word[WORD_BITS-1];
                    if (half_done) begin
                        state <= HIGH;
                    end
                end
                HIGH: begin
                    if (half_done) begin
                        link.sclk <= 1'b0;
                        bits_left <= bits_left - CNT_BITS'(1);
                        shift_word <= {shift_word[WORD_BITS-2:0], 1'b0};
                        state <= LOW;
                    end
                end
                LOW: begin
                    if (half_done) begin
                        link.sclk <= 1'b1;
                        if (bits_left == '0) begin
                            link.frame_sync_n <= 1'b1;
                            state <= IDLE;
                        end else begin
                            link.serial_data_in <= shift_word[WORD_BITS-1];
                            state <= HIGH;
                        end
                    end
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end
endmodule

// ### tb/dds_link_assertions.sv
`timescale 1ns/1ps
// Purpose: wire checks on the host to device serial link
// Assumes: link signals move on sys_clk edges only
// Notes: sees only the link, so datapath checks live in the bench
module dds_link_assertions (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic serial_data_in,
    input wire logic frame_sync_n
);
    logic sclk_d;
    logic [4:0] falls;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // count serial clock falls in a frame; cleared while idle
    always_ff @(posedge sys_clk) begin
        sclk_d <= sclk;
    end
    always_ff @(posedge sys_clk) begin
        if (rst || frame_sync_n) begin
            falls <= 5'h00;
        end else if (sclk_d && !sclk) begin
            falls <= falls + 5'h01;
        end
    end

    AST_IDLE_HIGH: assert property (frame_sync_n |-> sclk)
        else $error("serial clock not high outside a frame");
    AST_START_SETUP: assert property ($fell(frame_sync_n) |-> sclk [*4] ##1 !sclk)
        else $error("first serial clock fall not at expected spacing");
    AST_FALL_IN_FRAME: assert property ($fell(sclk) |-> !frame_sync_n)
        else $error("serial clock fell outside a frame");
    AST_LOW_TWO: assert property ($fell(sclk) |=> !sclk ##1 sclk)
        else $error("serial clock low phase not two cycles");
    AST_HIGH_TWO: assert property ($rose(sclk) && !frame_sync_n |=> sclk ##1 !sclk)
        else $error("serial clock high phase not two cycles");
    AST_DATA_HELD: assert property (!sclk |-> $stable(serial_data_in))
        else $error("serial data moved while serial clock low");
    AST_SIXTEEN: assert property ($rose(frame_sync_n) |-> falls == 5'h10)
        else $error("frame did not carry sixteen bits");
    AST_FRAME_LEN: assert property ($fell(frame_sync_n) |-> ##[64:68] $rose(frame_sync_n))
        else $error("frame length out of range");
    AST_END_SCLK: assert property ($rose(frame_sync_n) |-> $rose(sclk))
        else $error("frame ended without serial clock rising");
endmodule

// ### tb/dds_digital_control_pins_tb_top.sv
`timescale 1ns/1ps
// Purpose: host and device joined by the link, driven from the user sides
// Assumes: inputs change on falling sys_clk edges
// Notes: phase_addr minus a cycle count exposes offset steps at step one
module dds_digital_control_pins_tb_top
    import dds_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [WORD_BITS-1:0] cmd_word = 16'h0000;
    logic freq_select = 1'b0;
    logic phase_select = 1'b0;
    logic clear_request = 1'b0;
    logic powerdown_request = 1'b0;
    logic comparator_result = 1'b0;
    logic cmd_ready, dac_powerdown, logic_out, logic_out_oe, comparator_from_pin, word_loaded;
    logic [PHASE_BITS-1:0] phase_addr;
    logic [11:0] cyc = 12'h000;
    logic sclk_prev = 1'b1;
    logic [15:0] wire_bits = 16'h0000;
    int wire_count = 0;
    int failures = 0;
    int checks = 0;

    always #5 sys_clk = ~sys_clk;

    dds_link_if dds_link_if_i ();
    dds_host dds_host_i (.sys_clk(sys_clk), .rst(rst), .link(dds_link_if_i), .cmd_valid(cmd_valid),
        .cmd_word(cmd_word), .cmd_ready(cmd_ready), .freq_select(freq_select), .phase_select(phase_select),
        .clear_request(clear_request), .powerdown_request(powerdown_request));
    dds_device dds_device_i (.sys_clk(sys_clk), .rst(rst), .link(dds_link_if_i),
        .comparator_result(comparator_result), .phase_addr(phase_addr), .dac_powerdown(dac_powerdown),
        .logic_out(logic_out), .logic_out_oe(logic_out_oe), .comparator_from_pin(comparator_from_pin),
        .word_loaded(word_loaded));
    dds_link_assertions dds_link_assertions_i (.sys_clk(sys_clk), .rst(rst), .sclk(dds_link_if_i.sclk),
        .serial_data_in(dds_link_if_i.serial_data_in), .frame_sync_n(dds_link_if_i.frame_sync_n));

    // cycle count and a sniffer of bits seen on the wire at serial clock falls
    always @(posedge sys_clk) begin
        cyc <= cyc + 12'h001;
        sclk_prev <= dds_link_if_i.sclk;
        if (sclk_prev && !dds_link_if_i.sclk && !dds_link_if_i.frame_sync_n) begin
            wire_bits <= {wire_bits[14:0], dds_link_if_i.serial_data_in};
            wire_count <= wire_count + 1;
        end
    end

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one word through the host; waits on handshakes with a bound
    task automatic send(logic [15:0] w);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        cmd_word = w;
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        check("busy", 16'h0000, {15'h0, cmd_ready});
        n = 0;
        while (word_loaded !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        check("word_loaded", 16'h0001, 16'(word_loaded));
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic step_check(string what, logic [11:0] exp);
        logic [11:0] p0;
        p0 = phase_addr;
        repeat (16) @(negedge sys_clk);
        // the difference wraps at twelve bits, so it is kept self-sized in the concatenation
        check(what, 16'(exp), {4'h0, phase_addr - p0});
    endtask

    // needs a step of one; the offset change shows as a jump against cyc
    task automatic offset_check(string what, logic [15:0] w, logic pin, logic [11:0] exp);
        logic [11:0] k0;
        k0 = phase_addr - cyc;
        phase_select = pin;
        send(w);
        check(what, 16'(exp), {4'h0, phase_addr - cyc - k0});
    endtask

    task automatic t_wire();
        int c0;
        c0 = wire_count;
        send(16'hB2C5);
        check("wire bits", 16'hB2C5, wire_bits);
        check("wire count", 16'h0010, 16'(wire_count - c0));
        $display("test wire done");
    endtask

    task automatic t_freq();
        logic [11:0] p0;
        send({TYPE_FREQ_A, 14'h0000});
        send({TYPE_FREQ_B, 14'h0000});
        send(16'h0009);
        send({TYPE_FREQ_A, 14'h0004});
        send({TYPE_FREQ_B, 14'h0008});
        step_check("step a", 12'h010);
        p0 = phase_addr;
        freq_select = 1'b1;
        repeat (16) @(negedge sys_clk);
        check("switch", 16'h0001, 16'(phase_addr - p0 > 12'h010 && phase_addr - p0 < 12'h020));
        step_check("step b", 12'h020);
        send(16'h0001); // pin stays high while the bit rules
        step_check("bit a", 12'h010);
        send(16'h0003);
        step_check("bit b", 12'h020);
        $display("test freq done");
    endtask

    task automatic t_phase();
        send(16'h0009);
        freq_select = 1'b0;
        repeat (4) @(negedge sys_clk);
        offset_check("load b", {TYPE_PHASE, 2'b10, 12'h100}, 1'b0, 12'h000);
        offset_check("pin b", 16'h0009, 1'b1, 12'h100);
        offset_check("bit a", 16'h0001, 1'b1, 12'hF00);
        offset_check("bit b", 16'h0005, 1'b1, 12'h100);
        offset_check("wrap", {TYPE_PHASE, 2'b10, 12'hF80}, 1'b1, 12'hE80);
        offset_check("pin a", 16'h0009, 1'b0, 12'h080);
        // offset a is written too, then put back to zero for the clear test
        offset_check("load a", {TYPE_PHASE, 2'b00, 12'h040}, 1'b0, 12'h040);
        offset_check("zero a", {TYPE_PHASE, 2'b00, 12'h000}, 1'b0, 12'hFC0);
        $display("test phase done");
    endtask

    task automatic t_clear();
        clear_request = 1'b1;
        @(negedge sys_clk);
        clear_request = 1'b0;
        repeat (2) @(negedge sys_clk);
        check("cleared", 16'h0001, 16'(phase_addr < 12'h008));
        step_check("kept word", 12'h010);
        $display("test clear done");
    endtask

    task automatic t_out();
        logic msb;
        powerdown_request = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("pd pin", 16'h0001, 16'(dac_powerdown));
        powerdown_request = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("pd off", 16'h0000, 16'(dac_powerdown));
        send(16'h0019);
        check("pd bit", 16'h0001, 16'(dac_powerdown));
        send(16'h0049);
        check("oe off", 16'h0000, {13'h0, logic_out_oe, logic_out, comparator_from_pin});
        send(16'h0069);
        comparator_result = 1'b1;
        repeat (3) @(negedge sys_clk);
        check("cmp high", 16'h0007, {13'h0, logic_out_oe, logic_out, comparator_from_pin});
        comparator_result = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("cmp low", 16'h0000, 16'(logic_out));
        send(16'h0029);
        // the logic output trails the address msb it copies by one register stage
        msb = phase_addr[PHASE_BITS-1];
        @(negedge sys_clk);
        check("msb", {13'h0, 1'b1, msb, 1'b0}, {13'h0, logic_out_oe, logic_out, comparator_from_pin});
        $display("test out done");
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // main sequence after six reset cycles
    initial begin
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        t_wire();
        t_freq();
        t_phase();
        t_clear();
        t_out();
        stop_test();
    end

    // a hung handshake would stall well short of this span
    initial begin
        #200000;
        failures++;
        stop_test();
    end
endmodule
